/* File: lcd_ctl_params.svh */
`ifndef LCD_CTL_PARAMS_SVH
`define LCD_CTL_PARAMS_SVH
// Notes on behaviour
// - fast clock base: fc over 2^17/16/15/13
// - frame rate: base, 4/3 base, 2x base
// - fast divisions in single or tap-clear dual, system clock select clear
// - slow clock base: fs over 2^9/2^8
// - reset: supply switch off, panel dark
// - enable bit one turns supply switch on
// - clearing enable keeps supply switch on
// - stop mode turns supply switch off
// - leaving stop restores prior drive state
// - reset: outputs low, shared pins released

// register byte offsets
`define LCD_OFS_CTRL 8'h00
`define LCD_OFS_MODE 8'h04
`define LCD_OFS_STAT 8'h08
// display control fields
`define LCD_EN_BIT 7
`define LCD_SLF_LSB 0
`define LCD_DUTY_LSB 4
// clock mode fields
`define LCD_DUAL_BIT 0
`define LCD_TAPSEL_BIT 1
`define LCD_SYSTEM_CLOCK_SELECT_BIT 2
// reset values
`define LCD_CTRL_RST 8'h00
`define LCD_MODE_RST 8'h00
// prescaler taps for the phase tick, base divisor over four
`define LCD_TAP_HI_00 5'd15
`define LCD_TAP_HI_01 5'd14
`define LCD_TAP_HI_10 5'd13
`define LCD_TAP_HI_11 5'd11
`define LCD_TAP_LO_00 5'd7
`define LCD_TAP_LO_01 5'd6
`endif

/* File: lcd_ctl_pkg.sv */
package lcd_ctl_pkg;
    // drive duty codes held in the control register
    typedef enum logic [1:0] {
        duty_quarter = 2'h0,
        duty_third = 2'h1,
        duty_half = 2'h2,
        duty_static = 2'h3
    } duty_e;
    typedef logic [7:0] reg_byte_t; // one stored register
endpackage : lcd_ctl_pkg

/* File: lcd_frame_and_power_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctl_params.svh"
module lcd_frame_and_power_control
    import lcd_ctl_pkg::*;
#(
    parameter int FAST_W = 17, // fast prescaler width
    parameter int SLOW_W = 9 // slow prescaler width
) (
    input wire logic core_clk_in, // fast clock, fc
    input wire logic arst_n_in, // async reset, low active
    input wire logic slow_clk_in, // low-frequency clock pin, fs
    input wire logic stop_mode_in, // core is in stop mode
    input wire logic wb_cyc_in, // wishbone cycle
    input wire logic wb_stb_in, // wishbone strobe
    input wire logic wb_we_in, // wishbone write
    input wire logic [7:0] wb_adr_in, // byte address
    input wire logic [3:0] wb_sel_in, // byte enables
    input wire logic [31:0] wb_dat_in, // write data
    output logic [31:0] wb_dat_out, // read data
    output logic wb_ack_out, // wishbone acknowledge
    output logic supply_switch_out, // drive supply pin switch on
    output logic [3:0] common_output_out, // active common, one-hot
    output logic shared_seg_oe_out, // shared segment pins driven
    output logic frame_tick_out // one pulse per frame
);

////////////////////////////////////////////////////////////////////////
// registers and bus slave

reg_byte_t ctrl_ff; // display control register
reg_byte_t mode_ff; // clock mode register
logic latched_ff; // supply switch enabled since reset
logic ack_ff; // acknowledge
logic [31:0] rd_ff; // read data
reg_byte_t stat_w; // live status byte

wire req_w = wb_cyc_in && wb_stb_in && !ack_ff; // new request
wire wr_w = req_w && wb_we_in && wb_sel_in[0]; // low lane write
wire hit_ctrl_w = (wb_adr_in == `LCD_OFS_CTRL);
wire hit_mode_w = (wb_adr_in == `LCD_OFS_MODE);
wire hit_stat_w = (wb_adr_in == `LCD_OFS_STAT);
wire en_bit_w = ctrl_ff[`LCD_EN_BIT]; // display enable bit
wire [1:0] slf_w = ctrl_ff[`LCD_SLF_LSB +: 2]; // base freq select
wire duty_e duty_w = duty_e'(ctrl_ff[`LCD_DUTY_LSB +: 2]);
wire dual_w = mode_ff[`LCD_DUAL_BIT]; // dual clock mode
wire tapsel_w = mode_ff[`LCD_TAPSEL_BIT]; // divider tap select
wire system_clock_select_w = mode_ff[`LCD_SYSTEM_CLOCK_SELECT_BIT]; // system clock select
// slow source when tap select in dual mode or system clock is slow
wire src_low_w = (dual_w && tapsel_w) || system_clock_select_w;
// a write of one to the enable bit latches the switch on
wire en_wr_w = wr_w && hit_ctrl_w && wb_dat_in[`LCD_EN_BIT];
wire nxt_latched = latched_ff || en_wr_w;
wire [31:0] nxt_rd = hit_ctrl_w ? {24'h0, ctrl_ff} :
                     hit_mode_w ? {24'h0, mode_ff} :
                     hit_stat_w ? {24'h0, stat_w} : 32'h0;

// register writes and the switch latch; only reset clears the latch
always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        ctrl_ff <= `LCD_CTRL_RST;
        mode_ff <= `LCD_MODE_RST;
        latched_ff <= 1'b0;
    end else begin
        if (wr_w && hit_ctrl_w) begin
            ctrl_ff <= wb_dat_in[7:0];
        end
        if (wr_w && hit_mode_w) begin
            mode_ff <= {5'h0, wb_dat_in[2:0]};
        end
        latched_ff <= nxt_latched;
    end
end

// one-wait answer; unmapped reads give zero, writes are dropped
always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        ack_ff <= 1'b0;
        rd_ff <= 32'h0;
    end else begin
        ack_ff <= req_w;
        if (req_w) begin
            rd_ff <= nxt_rd;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// slow clock synchroniser

logic s1_ff, s2_ff, s3_ff; // three-stage capture
logic slow_lvl_ff; // accepted level

wire agree_w = (s2_ff == s3_ff); // stages two and three agree
wire slow_rise_w = agree_w && s2_ff && !slow_lvl_ff; // rising edge

// first stage feeds only the second
always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        s3_ff <= 1'b0;
        slow_lvl_ff <= 1'b0;
    end else begin
        s1_ff <= slow_clk_in;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (agree_w) begin
            slow_lvl_ff <= s2_ff;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// prescalers and tap selection

// low bits mask below a tap
function automatic logic [16:0] tap_mask(input logic [4:0] tap);
    tap_mask = 17'((18'h1 << tap) - 18'h1);
endfunction : tap_mask

logic [FAST_W-1:0] fast_cnt_ff; // free fast prescaler
logic [SLOW_W-1:0] slow_cnt_ff; // free slow prescaler

// fast tap per select code
wire [4:0] tap_hi_w = (slf_w == 2'h0) ? `LCD_TAP_HI_00 :
                      (slf_w == 2'h1) ? `LCD_TAP_HI_01 :
                      (slf_w == 2'h2) ? `LCD_TAP_HI_10 :
                      `LCD_TAP_HI_11;
// slow tap; codes above one fall back to the shorter division
wire [4:0] tap_lo_w = (slf_w == 2'h0) ? `LCD_TAP_LO_00 :
                      `LCD_TAP_LO_01;
wire [16:0] m_hi_w = tap_mask(tap_hi_w);
wire [16:0] m_lo_w = tap_mask(tap_lo_w);
wire [16:0] fast_x_w = 17'(fast_cnt_ff);
wire [16:0] slow_x_w = 17'(slow_cnt_ff);
wire fast_tk_w = ((fast_x_w & m_hi_w) == m_hi_w);
wire slow_tk_w = slow_rise_w && ((slow_x_w & m_lo_w) == m_lo_w);
// phase tick at four times the base frequency
wire phase_tk_w = !stop_mode_in &&
                  (src_low_w ? slow_tk_w : fast_tk_w);

// prescalers run freely, held still in stop mode
always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        fast_cnt_ff <= '0;
        slow_cnt_ff <= '0;
    end else if (!stop_mode_in) begin
        fast_cnt_ff <= fast_cnt_ff + 1'b1;
        if (slow_rise_w) begin
            slow_cnt_ff <= slow_cnt_ff + 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// common phase sequencer and outputs

logic [1:0] phase_ff; // current common phase
logic supply_ff; // supply switch output
logic [3:0] com_ff; // common output register
logic shared_oe_ff; // shared pin enable
logic frame_ff; // frame pulse

// last phase: four for quarter and static, three, two
wire [1:0] last_w = (duty_w == duty_third) ? 2'h2 :
                    (duty_w == duty_half) ? 2'h1 : 2'h3;
wire run_w = latched_ff && !stop_mode_in; // driver operating
wire wrap_w = run_w && phase_tk_w && (phase_ff == last_w);
wire [1:0] nxt_phase = !run_w ? phase_ff :
                       !phase_tk_w ? phase_ff :
                       (phase_ff == last_w) ? 2'h0 :
                       2'(phase_ff + 2'h1);
// static drive keeps common zero selected
wire [1:0] sel_w = (duty_w == duty_static) ? 2'h0 : nxt_phase;
wire [3:0] nxt_com = (run_w && en_bit_w) ? 4'(4'h1 << sel_w) : 4'h0;
// stop forces the switch off; the latch brings it back afterwards
wire nxt_supply = nxt_latched && !stop_mode_in;

assign stat_w = {3'h0, stop_mode_in, phase_ff, src_low_w, supply_ff};

// phase and pin registers; all dark and low during reset
always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        phase_ff <= 2'h0;
        supply_ff <= 1'b0;
        com_ff <= 4'h0;
        shared_oe_ff <= 1'b0;
        frame_ff <= 1'b0;
    end else begin
        phase_ff <= nxt_phase;
        supply_ff <= nxt_supply;
        com_ff <= nxt_com;
        shared_oe_ff <= 1'b1;
        frame_ff <= wrap_w;
    end
end

assign wb_dat_out = rd_ff;
assign wb_ack_out = ack_ff;
assign supply_switch_out = supply_ff;
assign common_output_out = com_ff;
assign shared_seg_oe_out = shared_oe_ff;
assign frame_tick_out = frame_ff;

////////////////////////////////////////////////////////////////////////
// checks

logic [15:0] gap_ff; // cycles since last phase tick
logic [2:0] cfg_ff; // source and select at last tick
logic seen_ff; // gap is valid

wire [2:0] cfg_w = {src_low_w, slf_w};

// measures spacing of phase ticks under a stable setting
always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        gap_ff <= 16'h0;
        cfg_ff <= 3'h0;
        seen_ff <= 1'b0;
    end else begin
        gap_ff <= phase_tk_w ? 16'h0 : 16'(gap_ff + 16'h1);
        cfg_ff <= phase_tk_w ? cfg_w : cfg_ff;
        seen_ff <= phase_tk_w ? 1'b1 :
                   (stop_mode_in || cfg_w != cfg_ff) ? 1'b0 : seen_ff;
    end
end

default clocking cb @(posedge core_clk_in); endclocking
default disable iff (!arst_n_in);

property p_fast_div;
    phase_tk_w && seen_ff && !src_low_w && cfg_w == cfg_ff |->
        {1'b0, gap_ff} == m_hi_w;
endproperty
a_fast_div: assert property (p_fast_div)
    else $error("fast phase tick spacing wrong");

property p_frame_len;
    frame_ff |-> $past(phase_ff) == $past(last_w);
endproperty
a_frame_len: assert property (p_frame_len)
    else $error("frame ended on wrong phase");

property p_src_fast;
    !dual_w && !system_clock_select_w && phase_tk_w |-> fast_tk_w;
endproperty
a_src_fast: assert property (p_src_fast)
    else $error("single clock mode not on fast prescaler");

property p_src_slow;
    src_low_w && phase_tk_w |-> slow_rise_w;
endproperty
a_src_slow: assert property (p_src_slow)
    else $error("slow source ticked without slow edge");

property p_dark;
    !latched_ff |-> !supply_switch_out && common_output_out == 4'h0;
endproperty
a_dark: assert property (p_dark)
    else $error("panel driven before supply enabled");

property p_enable;
    en_wr_w && !stop_mode_in ##1 !stop_mode_in |-> supply_switch_out;
endproperty
a_enable: assert property (p_enable)
    else $error("enable write did not close switch");

property p_hold;
    latched_ff |=> latched_ff [*4];
endproperty
a_hold: assert property (p_hold)
    else $error("supply switch latch dropped");

property p_stop;
    stop_mode_in |=> !supply_switch_out && common_output_out == 4'h0;
endproperty
a_stop: assert property (p_stop)
    else $error("switch on during stop");

property p_resume;
    $fell(stop_mode_in) && latched_ff |=> supply_switch_out;
endproperty
a_resume: assert property (p_resume)
    else $error("drive not restored after stop");

property p_halt;
    stop_mode_in |=> $stable(fast_cnt_ff) && !frame_tick_out;
endproperty
a_halt: assert property (p_halt)
    else $error("prescaler moved in stop");

c_frame: cover property (frame_ff && duty_w == duty_third);
c_slow: cover property (src_low_w && frame_ff);
c_resume: cover property ($fell(stop_mode_in) && latched_ff);
// half duty frames and a stop entered while the switch is latched
c_half: cover property (frame_ff && duty_w == duty_half);
c_stop: cover property (stop_mode_in && latched_ff);

endmodule : lcd_frame_and_power_control
`default_nettype wire

/* File: lcd_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// panel model: counts lit frames and flags illegal common patterns
module lcd_panel_model (
    input wire logic clk_in, // core clock
    input wire logic supply_in, // drive supply present
    input wire logic [3:0] common_in, // common lines
    input wire logic frame_in, // frame pulse
    output int frames_out, // frames seen while powered
    output int bad_out // cycles with two commons active
);
    ////////////////////////////////////////
    // the glass only sees frames while drive voltage is present
    always @(posedge clk_in) begin
        if (supply_in && frame_in === 1'b1) begin
            frames_out <= frames_out + 1;
        end
        if ($countones(common_in) > 1) begin
            bad_out <= bad_out + 1; // two selected commons
        end
    end
endmodule : lcd_panel_model
`default_nettype wire

/* File: tb_lcd_frame_and_power_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctl_params.svh"
module tb_lcd_frame_and_power_control;
    import lcd_ctl_pkg::*;
    logic clk = 0, rst_n = 0, slow = 0, stop = 0; // clocks and modes
    logic cyc = 0, stb = 0, we = 0; // bus strobes
    logic [7:0] adr = 0; // bus address
    logic [3:0] sel = 0; // byte enables
    logic [31:0] dat = 0, r; // write data, read result
    wire logic [31:0] rdat; // read data
    wire logic ack, sup, oe, ftick; // design outputs
    wire logic [3:0] common_output; // common lines
    int num_errors = 0, checks = 0, ncyc = 0, n, sdiv = 0, frames, bad;
    ////////////////////////////////////////
    lcd_frame_and_power_control dut_u (.core_clk_in(clk),
        .arst_n_in(rst_n), .slow_clk_in(slow), .stop_mode_in(stop),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .supply_switch_out(sup),
        .common_output_out(common_output), .shared_seg_oe_out(oe),
        .frame_tick_out(ftick));
    lcd_panel_model panel_u (.clk_in(clk), .supply_in(sup),
        .common_in(common_output), .frame_in(ftick), .frames_out(frames),
        .bad_out(bad));
    ////////////////////////////////////////
    always #5 clk = ~clk; // 100 MHz core clock
    // slow clock of 20 core cycles, plus the hang limit
    always @(posedge clk) begin
        sdiv <= (sdiv == 9) ? 0 : sdiv + 1;
        if (sdiv == 9) begin
            slow <= ~slow;
        end
        ncyc <= ncyc + 1;
        if (ncyc == 98000) begin
            num_errors++;
            finish_test();
        end
    end
    ////////////////////////////////////////
    // compare one value and count it
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // one classic wishbone cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do @(posedge clk); while (ack !== 1'b1 && ++k < 50);
        if (ack !== 1'b1) begin
            num_errors++; // no answer counts as a mismatch
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    // cycles between two common changes or two frame pulses
    task automatic period(input bit tick);
        logic [3:0] last;
        repeat (2) begin
            n = 0;
            do begin
                last = common_output;
                @(posedge clk);
                n++;
            end while ((tick ? ftick !== 1'b1 : common_output === last) && n < 40000);
        end
    endtask : period
    // frame length in core cycles from duty and phase length
    function automatic int frame_len(int d, int ph);
        return (d == 1 ? 3 : d == 2 ? 2 : 4) * ph;
    endfunction : frame_len
    // counts then verdict
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////
    initial begin
        void'($urandom(15058));
        repeat (3) @(posedge clk);
        check(sup, 0);
        check(common_output, 0);
        check(oe, 0);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check(oe, 1);
        bus(0, `LCD_OFS_CTRL, 0);
        check(r, `LCD_CTRL_RST);
        // random data at an unmapped place and the mode register
        repeat (4) begin
            dat <= $urandom;
            bus(1, 8'h0c, $urandom);
            bus(0, 8'h0c, 0);
            check(r, 0);
            n = $urandom;
            bus(1, `LCD_OFS_MODE, n);
            bus(0, `LCD_OFS_MODE, 0);
            check(r, n & 32'h7);
        end
        bus(1, `LCD_OFS_MODE, 32'h01); // dual clock, tap clear
        bus(1, `LCD_OFS_CTRL, 32'h83);
        check(sup, 1);
        for (int i = 0; i < 2; i++) begin
            bus(1, `LCD_OFS_CTRL, 32'h80 | (3 - i));
            period(0);
            check(n, 2048 << (2 * i));
        end
        for (int d = 0; d < 4; d++) begin
            bus(1, `LCD_OFS_CTRL, 32'h83 | (d << 4));
            period(1);
            check(n, frame_len(d, 2048));
        end
        bus(1, `LCD_OFS_MODE, 32'h03); // dual clock, tap set
        bus(1, `LCD_OFS_CTRL, 32'h81);
        period(0);
        check(32'(n > 1277 && n < 1283), 1);
        bus(1, `LCD_OFS_MODE, 32'h04); // slow system clock
        bus(1, `LCD_OFS_CTRL, 32'h80);
        period(0);
        check(32'(n > 2557 && n < 2563), 1);
        bus(1, `LCD_OFS_CTRL, 32'h00);
        check(sup, 1);
        repeat (2) @(posedge clk);
        check(common_output, 0);
        stop <= 1'b1;
        repeat (2) @(posedge clk);
        check(sup, 0);
        stop <= 1'b0;
        repeat (2) @(posedge clk);
        check(sup, 1);
        bus(0, `LCD_OFS_STAT, 0);
        check(r & 32'h13, 32'h03);
        check(bad, 0);
        check(32'(frames > 0), 1);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        check(sup, 0);
        check(oe, 0);
        finish_test();
    end
endmodule : tb_lcd_frame_and_power_control
`default_nettype wire
